// ---- design/fsps_pkg.sv ----
// Purpose: constants for the flash self-programming sequencer
// Assumes: 32-bit AXI4-Lite register bus, 25 MHz core clock
// Notes: page geometry and region split are plain defaults
package fsps_pkg;
	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PTR = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_STROBE = 8'h0C;
	localparam logic [7:0] OFS_BOOT = 8'h10;
	localparam logic [7:0] OFS_RDADDR = 8'h14;
	localparam logic [7:0] OFS_RDDATA = 8'h18;
	localparam logic [7:0] OFS_BUFRD = 8'h1C;

	// ****************************************
	// control field positions
	// ****************************************
	localparam int B_EN = 0;
	localparam int B_ERASE = 1;
	localparam int B_WRITE = 2;
	localparam int B_LOCK = 3;
	localparam int B_REEN = 4;
	localparam int B_BUSY = 6;
	localparam int B_IE = 7;
	localparam logic [4:0] CMD_LOAD = 5'h01;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_LOCK = 5'h09;
	localparam logic [4:0] CMD_REEN = 5'h11;
	localparam logic [4:0] CMD_MASK = 5'h1F;

	// ****************************************
	// geometry and timing
	// ****************************************
	localparam int WORD_BITS = 6;
	localparam int PAGE_WORDS = 64;
	localparam logic [15:0] APP_ENTRY = 16'h0000;
	localparam logic [15:0] LOADER_ENTRY = 16'h1C00;
	localparam logic [15:0] HALT_REGION_START = 16'h1C00;
	localparam logic [2:0] WINDOW_CYCLES = 3'd4;
	localparam int CLK_HZ = 25_000_000;
	localparam int PROG_TIME_US = 3700;
	localparam int PROG_CYCLES = (CLK_HZ / 1000) * PROG_TIME_US / 1000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PROG} fsps_state_t;
endpackage

// ---- design/fsps_top.sv ----
// Purpose: self-programming sequencer for on-chip program flash
// Assumes: store instruction arrives as a strobe register write
// Notes: lock bits and fuse readback left out; fuse is a pin
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

// Behaviour
// - boot fuse high selects entry 0x0000, low selects loader start.
// - software has no path that writes the boot fuse.
// - 16-bit pointer: upper bits page, low bits word in page.
// - target address latched when an operation starts.
// - lock-bit setting starts no flash operation, but the pointer page still loads flash_op_addr.
// - byte reads use read-address register bit 0 to pick low or high byte.
// - erase: code X0000011 then store within four cycles.
// - erase uses page field only, ignores word field and data.
// - load: data pair, code 00000001, store within four cycles, word slot.
// - buffer clears after page write, on re-enable, and at reset.
// - data-EEPROM write during loading discards loaded words.
// - write: code X0000101, store within four cycles, buffer to page.
// - halting-region target stalls the core; other region keeps running.
// - region reads blocked and busy flag set during erase or write.
// - busy flag stays until software writes re-enable bit.
// - interrupt level held while enable bit is zero and enabled.
// - buffer loads accepted in any slot order, before or after erase.
// - no store within four cycles clears enable and command bits.
// - erase, write or lock write lasts 3.7 ms to 4.5 ms; here lock ends at once, erase and write take 3.7 ms.
module fsps_top
	import fsps_pkg::*;
#(
	parameter int PROG_CYC = PROG_CYCLES
)(
	input wire logic clk,
	input wire logic nrst,
	input wire logic boot_reset_select_fuse,
	input wire logic eeprom_write,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [15:0] reset_vector,
	output logic core_stall,
	output logic region_read_block,
	output logic selfprog_irq,
	output logic flash_op_start,
	output logic [15:0] flash_op_addr,
	output logic [1:0] flash_op_kind
);
	import fsps_pkg::*;

	// ****************************************
	// storage and state
	// ****************************************
	logic [7:0] ctrl_reg;
	logic [15:0] ptr_reg;
	logic [15:0] data_reg;
	logic [15:0] rdaddr_reg;
	logic [15:0] buf_mem [PAGE_WORDS];
	logic [PAGE_WORDS-1:0] buf_valid_reg;
	logic [15:0] op_addr_reg;
	logic [2:0] win_reg;
	logic [31:0] prog_cnt_reg;
	logic [2:0] fuse_sync_reg;
	logic fuse_level_reg;
	logic [2:0] ee_sync_reg;
	fsps_state_t state_reg;
	logic [31:0] aw_addr_reg;
	logic aw_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic w_held_reg;

	logic wr_fire;
	logic rd_fire;
	logic [7:0] wr_ofs;
	logic store_hit;
	logic prog_done;
	logic ee_edge;

	function automatic logic in_halt(input logic [15:0] a);
		return a >= HALT_REGION_START;
	endfunction

	function automatic logic [7:0] ofs_of(input logic [31:0] a);
		return {a[7:2], 2'b00};
	endfunction

	// ****************************************
	// input synchronisers
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fuse_sync_reg <= 3'h7;
			ee_sync_reg <= 3'h0;
		end else begin
			fuse_sync_reg <= {fuse_sync_reg[1:0], boot_reset_select_fuse};
			ee_sync_reg <= {ee_sync_reg[1:0], eeprom_write};
		end
	end

	// fuse reaches logic by pin only, never by the bus
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			fuse_level_reg <= 1'b1;
		else if (fuse_sync_reg[1] == fuse_sync_reg[2])
			fuse_level_reg <= fuse_sync_reg[2];
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			reset_vector <= APP_ENTRY;
		else
			reset_vector <= fuse_level_reg ? APP_ENTRY : LOADER_ENTRY;
	end

	assign ee_edge = (ee_sync_reg[1] == ee_sync_reg[2]) && ee_sync_reg[2];

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wr_ofs = ofs_of(aw_addr_reg);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 32'h0000_0000;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held_reg && !s_axi_awready;
			s_axi_wready <= !w_held_reg && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_ofs > OFS_STROBE && wr_ofs != OFS_RDADDR) ?
					RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// pointer and data registers
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ptr_reg <= 16'h0000;
			data_reg <= 16'h0000;
			rdaddr_reg <= 16'h0000;
		end else if (wr_fire) begin
			if (wr_ofs == OFS_PTR) begin
				if (w_strb_reg[0]) ptr_reg[7:0] <= w_data_reg[7:0];
				if (w_strb_reg[1]) ptr_reg[15:8] <= w_data_reg[15:8];
			end
			if (wr_ofs == OFS_DATA) begin
				if (w_strb_reg[0]) data_reg[7:0] <= w_data_reg[7:0];
				if (w_strb_reg[1]) data_reg[15:8] <= w_data_reg[15:8];
			end
			if (wr_ofs == OFS_RDADDR) begin
				if (w_strb_reg[0]) rdaddr_reg[7:0] <= w_data_reg[7:0];
				if (w_strb_reg[1]) rdaddr_reg[15:8] <= w_data_reg[15:8];
			end
		end
	end

	// ****************************************
	// command sequencer
	// ****************************************
	assign store_hit = wr_fire && (wr_ofs == OFS_STROBE) && state_reg == ST_ARMED;
	assign prog_done = state_reg == ST_PROG && prog_cnt_reg == 32'(PROG_CYC - 1);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
			ctrl_reg <= 8'h00;
			win_reg <= 3'd0;
			prog_cnt_reg <= 32'h0000_0000;
			op_addr_reg <= 16'h0000;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (wr_fire && wr_ofs == OFS_CTRL && w_strb_reg[0]) begin
						ctrl_reg[B_IE] <= w_data_reg[B_IE];
						ctrl_reg[4:0] <= w_data_reg[4:0];
						if (w_data_reg[B_EN]) begin
							state_reg <= ST_ARMED;
							win_reg <= 3'd0;
						end
					end
				end
				ST_ARMED: begin
					win_reg <= win_reg + 3'd1;
					if (store_hit) begin
						op_addr_reg <= ptr_reg;
						case (ctrl_reg[4:0] & CMD_MASK)
							CMD_ERASE, CMD_WRITE: begin
								ctrl_reg[B_BUSY] <= 1'b1;
								prog_cnt_reg <= 32'h0000_0000;
								state_reg <= ST_PROG;
							end
							CMD_REEN: begin
								ctrl_reg[B_BUSY] <= 1'b0;
								ctrl_reg[4:0] <= 5'h00;
								state_reg <= ST_IDLE;
							end
							default: begin
								// lock or load finishes at once
								ctrl_reg[4:0] <= 5'h00;
								state_reg <= ST_IDLE;
							end
						endcase
					end else if (win_reg == WINDOW_CYCLES - 3'd1) begin
						ctrl_reg[4:0] <= 5'h00;
						state_reg <= ST_IDLE;
					end
				end
				ST_PROG: begin
					prog_cnt_reg <= prog_cnt_reg + 32'd1;
					if (prog_done) begin
						ctrl_reg[4:0] <= 5'h00;
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// temporary page buffer
	// ****************************************
	// buffer clear sources; eeprom discard
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			buf_valid_reg <= '0;
		else if (ee_edge && |buf_valid_reg)
			buf_valid_reg <= '0;
		else if (prog_done && ctrl_reg[4:0] == CMD_WRITE)
			buf_valid_reg <= '0;
		else if (store_hit && ctrl_reg[4:0] == CMD_REEN)
			buf_valid_reg <= '0;
		else if (store_hit && ctrl_reg[4:0] == CMD_LOAD)
			buf_valid_reg[ptr_reg[WORD_BITS:1]] <= 1'b1;
	end

	// relies on single loads per slot
	always_ff @(posedge clk) begin
		if (store_hit && ctrl_reg[4:0] == CMD_LOAD)
			buf_mem[ptr_reg[WORD_BITS:1]] <= data_reg;
	end

	// ****************************************
	// flash macro handoff and region control
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flash_op_start <= 1'b0;
			flash_op_addr <= 16'h0000;
			flash_op_kind <= 2'b00;
		end else begin
			flash_op_start <= store_hit && (ctrl_reg[4:0] == CMD_ERASE ||
				ctrl_reg[4:0] == CMD_WRITE);
			if (store_hit) begin
				flash_op_addr <= {ptr_reg[15:WORD_BITS+1], {(WORD_BITS+1){1'b0}}};
				flash_op_kind <= (ctrl_reg[4:0] == CMD_WRITE) ? 2'b10 : 2'b01;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			core_stall <= 1'b0;
			region_read_block <= 1'b0;
			selfprog_irq <= 1'b0;
		end else begin
			core_stall <= state_reg == ST_PROG && in_halt(op_addr_reg) && !prog_done;
			region_read_block <= ctrl_reg[B_BUSY];
			selfprog_irq <= ctrl_reg[B_IE] && !ctrl_reg[B_EN];
		end
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !rd_fire;
			if (rd_fire) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				case (ofs_of(s_axi_araddr))
					OFS_CTRL: s_axi_rdata <= {24'h00_0000, ctrl_reg};
					OFS_PTR: s_axi_rdata <= {16'h0000, ptr_reg};
					OFS_DATA: s_axi_rdata <= {16'h0000, data_reg};
					OFS_STROBE: s_axi_rdata <= 32'h0000_0000;
					OFS_BOOT: s_axi_rdata <= {16'h0000, reset_vector};
					OFS_RDADDR: s_axi_rdata <= {16'h0000, rdaddr_reg};
					OFS_RDDATA: s_axi_rdata <= {24'h00_0000, rdaddr_reg[0] ?
						buf_mem[rdaddr_reg[WORD_BITS:1]][15:8] :
						buf_mem[rdaddr_reg[WORD_BITS:1]][7:0]};
					OFS_BUFRD: s_axi_rdata <= buf_valid_reg[31:0];
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// ---- testbench/flash_self_programming_sequencer_tb.sv ----
// Purpose: self-checking bench for fsps_top
// Assumes: short programming count via PROG_CYC
// Notes: reads noted in a queue, checked by a monitor
`timescale 1ns/1ps
module flash_self_programming_sequencer_tb;
	import fsps_pkg::*;
	localparam int PC = 20;
	logic clk = 1'h0, nrst = 1'h0, boot_reset_select_fuse = 1'h1, eeprom_write = 1'h0;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, flash_op_kind;
	logic [15:0] reset_vector, flash_op_addr, p, d;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic core_stall, region_read_block, selfprog_irq, flash_op_start;
	logic [65:0] rq[$];
	logic [17:0] oq[$];
	logic [1:0] bq[$];
	int n_fail = 0, n_tests = 0;
	always #20 clk = ~clk;
	fsps_top #(.PROG_CYC(PC)) uut (
		.clk(clk),
		.nrst(nrst),
		.boot_reset_select_fuse(boot_reset_select_fuse),
		.eeprom_write(eeprom_write),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.reset_vector(reset_vector),
		.core_stall(core_stall),
		.region_read_block(region_read_block),
		.selfprog_irq(selfprog_irq),
		.flash_op_start(flash_op_start),
		.flash_op_addr(flash_op_addr),
		.flash_op_kind(flash_op_kind)
	);
	fsps_core u_core (
		.clk(clk),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready)
	);
	// ****************************************
	// compares and tasks
	// ****************************************
	task automatic bad(input string s);
		n_fail++;
		$display("CHECK FAILED %0t %s", $time, s);
	endtask
	task automatic chk_rd(input logic [65:0] e);
		n_tests++;
		if ((s_axi_rdata & e[63:32]) !== e[31:0] || s_axi_rresp !== e[65:64]) bad("read");
	endtask
	task automatic chk_op(input logic [17:0] e);
		n_tests++;
		if ({flash_op_kind, flash_op_addr} !== e) bad("op");
	endtask
	task automatic chk_bit(input logic v, input logic e);
		n_tests++;
		if (v !== e) bad("flag");
	endtask
	task automatic chk_resp(input logic [1:0] e);
		n_tests++;
		if (s_axi_bresp !== e) bad("write response");
	endtask
	task automatic exp_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v,
		input logic [1:0] r = RESP_OKAY);
		rq.push_back({r, m, v});
		u_core.rd(a);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic ld(input logic [5:0] s, input logic [15:0] v);
		u_core.wr(OFS_PTR, {25'h000_0000, s, 1'h0});
		u_core.wr(OFS_DATA, {16'h0000, v});
		u_core.wr(OFS_CTRL, {27'h000_0000, CMD_LOAD});
		u_core.wr(OFS_STROBE, 32'h0000_0000);
	endtask
	task automatic prog(input logic [31:0] c, input logic [15:0] a, input logic [1:0] k);
		u_core.wr(OFS_PTR, {16'h0000, a});
		u_core.wr(OFS_CTRL, c);
		oq.push_back({k, a & 16'hFF80});
		u_core.wr(OFS_STROBE, 32'h0000_0000);
	endtask
	task automatic reen;
		u_core.wr(OFS_CTRL, {27'h000_0000, CMD_REEN});
		u_core.wr(OFS_STROBE, 32'h0000_0000);
	endtask
	task automatic conclude;
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		if (s_axi_rvalid && s_axi_rready) chk_rd(rq.pop_front());
		if (flash_op_start === 1'h1) chk_op(oq.pop_front());
		if (s_axi_bvalid && s_axi_bready) chk_resp(bq.pop_front());
		if (s_axi_awvalid && s_axi_awready)
			bq.push_back((s_axi_awaddr[7:0] inside {OFS_CTRL, OFS_PTR, OFS_DATA, OFS_STROBE,
				OFS_RDADDR}) ? RESP_OKAY : RESP_SLVERR);
	end
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		void'($urandom(32'h0d56_6f9a));
		cyc(12);
		nrst <= 1'h1;
		@(posedge clk);
		exp_rd(OFS_BOOT, '1, 32'h0000_0000);
		boot_reset_select_fuse <= 1'h0;
		cyc(10);
		exp_rd(OFS_BOOT, '1, {16'h0000, LOADER_ENTRY});
		u_core.wr(OFS_BOOT, 32'h0000_0000);
		exp_rd(OFS_BOOT, '1, {16'h0000, LOADER_ENTRY});
		d = 16'($urandom);
		ld(6'h05, d);
		ld(6'h02, 16'($urandom));
		u_core.wr(OFS_RDADDR, 32'h0000_000B);
		exp_rd(OFS_RDDATA, '1, {24'h00_0000, d[15:8]});
		u_core.wr(OFS_RDADDR, 32'h0000_000A);
		exp_rd(OFS_RDDATA, '1, {24'h00_0000, d[7:0]});
		exp_rd(OFS_CTRL, 32'h0000_0001, 32'h0000_0000);
		exp_rd(OFS_BUFRD, '1, 32'h0000_0024);
		eeprom_write <= 1'h1;
		cyc(4);
		eeprom_write <= 1'h0;
		cyc(6);
		exp_rd(OFS_BUFRD, '1, 32'h0000_0000);
		ld(6'h03, 16'($urandom));
		p = 16'($urandom_range(0, 32'h0000_1BFF));
		prog(32'h0000_0083, p, 2'h1);
		u_core.wr(OFS_PTR, 32'h0000_FFFF);
		chk_op({2'h1, p & 16'hFF80});
		exp_rd(OFS_CTRL, 32'h0000_0041, 32'h0000_0041);
		cyc(2 * PC);
		exp_rd(OFS_CTRL, 32'h0000_0041, 32'h0000_0040);
		chk_bit(selfprog_irq, 1'h1);
		reen;
		exp_rd(OFS_CTRL, 32'h0000_0040, 32'h0000_0000);
		exp_rd(OFS_BUFRD, '1, 32'h0000_0000);
		prog(32'h0000_0003, HALT_REGION_START, 2'h1);
		cyc(2 * PC);
		reen;
		ld(6'h00, 16'($urandom));
		prog(32'h0000_0005, HALT_REGION_START, 2'h2);
		cyc(2);
		chk_bit(core_stall, 1'h1);
		cyc(2 * PC);
		exp_rd(OFS_BUFRD, '1, 32'h0000_0000);
		reen;
		u_core.wr(OFS_CTRL, 32'h0000_0001);
		cyc(10);
		exp_rd(OFS_CTRL, 32'h0000_001F, 32'h0000_0000);
		u_core.wr(OFS_CTRL, {27'h000_0000, CMD_LOCK});
		u_core.wr(OFS_STROBE, 32'h0000_0000);
		exp_rd(OFS_CTRL, 32'h0000_005F, 32'h0000_0000);
		ld(6'h07, 16'($urandom));
		exp_rd(OFS_BUFRD, '1, 32'h0000_0080);
		nrst <= 1'h0;
		cyc(2);
		nrst <= 1'h1;
		cyc(2);
		exp_rd(OFS_BUFRD, '1, 32'h0000_0000);
		exp_rd(8'h20, '1, 32'h0000_0000, RESP_SLVERR);
		cyc(4);
		conclude();
	end
	// whole run is a few hundred cycles; ample margin
	initial begin
		cyc(20000);
		n_fail++;
		conclude();
	end
endmodule

// ---- testbench/fsps_assertions.sv ----
// Purpose: port-level checks on fsps_top
// Assumes: one clock domain, nrst async active low
// Notes: bound into every fsps_top instance
`timescale 1ns/1ps
module fsps_chk
	import fsps_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic boot_reset_select_fuse,
	input wire logic [15:0] reset_vector,
	input wire logic core_stall,
	input wire logic region_read_block,
	input wire logic flash_op_start,
	input wire logic [15:0] flash_op_addr,
	input wire logic [1:0] flash_op_kind
);
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_vec_app: assert property (
		boot_reset_select_fuse [*8] |-> reset_vector == APP_ENTRY)
		else $error("vector not application entry");
	a_vec_loader: assert property (
		!boot_reset_select_fuse [*8] |-> reset_vector == LOADER_ENTRY)
		else $error("vector not loader entry");
	a_op_pulse: assert property (
		flash_op_start |=> !flash_op_start)
		else $error("start longer than one cycle");
	a_op_page: assert property (
		flash_op_start |-> flash_op_addr[6:0] == 7'h00 && flash_op_kind inside {2'h1, 2'h2})
		else $error("op address or kind malformed");
	a_busy_hold: assert property (
		flash_op_start |-> ##1 region_read_block [*8])
		else $error("busy dropped during op");
	a_busy_cause: assert property (
		$rose(region_read_block) |-> flash_op_start || $past(flash_op_start))
		else $error("busy without an op");
	a_stall_halt: assert property (
		flash_op_start && flash_op_addr >= HALT_REGION_START |-> ##[1:2] core_stall)
		else $error("no stall for halting region");
	a_stall_rww: assert property (
		flash_op_start && flash_op_addr < HALT_REGION_START |=> !core_stall [*4])
		else $error("stall for other region");
endmodule
bind fsps_top fsps_chk u_chk (
	.clk(clk),
	.nrst(nrst),
	.boot_reset_select_fuse(boot_reset_select_fuse),
	.reset_vector(reset_vector),
	.core_stall(core_stall),
	.region_read_block(region_read_block),
	.flash_op_start(flash_op_start),
	.flash_op_addr(flash_op_addr),
	.flash_op_kind(flash_op_kind)
);

// ---- testbench/fsps_core.sv ----
// Purpose: core model issuing register and store accesses
// Assumes: AXI4-Lite master, one access at a time
// Notes: response ready held high, so no release race
`timescale 1ns/1ps
module fsps_core (
	input wire logic clk,
	output logic [31:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [31:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// ****************************************
	// bus tasks
	// ****************************************
	initial begin
		s_axi_awaddr = '0;
		s_axi_awvalid = 1'h0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		s_axi_wvalid = 1'h0;
		s_axi_bready = 1'h1;
		s_axi_araddr = '0;
		s_axi_arvalid = 1'h0;
		s_axi_rready = 1'h1;
	end
	// next access starts on the response edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ad;
		logic wd;
		ad = 1'h0;
		wd = 1'h0;
		s_axi_awaddr <= {24'h00_0000, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) begin
				ad = 1'h1;
				s_axi_awvalid <= 1'h0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd = 1'h1;
				s_axi_wvalid <= 1'h0;
			end
		end
		do @(posedge clk); while (!s_axi_bvalid);
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= {24'h00_0000, a};
		s_axi_arvalid <= 1'h1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk); while (!s_axi_rvalid);
	endtask
endmodule
